// >>> core/spa_pkg.sv
// What this block does
// - Address and mask registers reset to zero
// - Receive and transmit flags form one request
// - Request passes only with both enables
// - Receive flag at stop or ninth bit
// - Bit 7 is framing error when selected
// - Bits 7 and 6 select serial mode
// - Bit 5 enables address recognition
// - Bit 4 gates the receiver
// - Bit 3 sent as ninth bit
// - Bit 2 captures stop or ninth bit
// - Transmit flag set after last data bit
// - Receive flag set after filtered frame
// - Eight-bit address and mask registers
// - Generator run bit starts the counter
// - Transmit clock source select bit
// - Receive clock source select bit
// - High or low rate generation select
// - Mode 0 variable or fixed rate
// - Reserved generator bits read as zero
// - Eight-bit reload register, resets zero
// - Given address match under mask
// - Broadcast address is address OR mask
// - Mode 2 rate is clock/32 or clock/16
////////////////////////////////////////////////////////////////////////////
// Purpose: constants and carriers of the serial port register block
// Assumes: byte-wide special function register access on sys_clk
// Notes: offsets are the register addresses of the core's SFR space
package spa_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_RELOAD = 8'h91;
  localparam logic [7:0] ADDR_BGCTL = 8'h92;
  localparam logic [7:0] ADDR_SCTL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_SADR = 8'ha9;
  localparam logic [7:0] ADDR_SMSK = 8'hb9;
  // Serial control bit positions
  localparam int B_MODE_LO = 7;
  localparam int B_MODE_HI = 6;
  localparam int B_MP_EN = 5;
  localparam int B_RX_EN = 4;
  localparam int B_TX9 = 3;
  localparam int B_RX9 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;
  // Generator control bit positions
  localparam int B_RUN = 4;
  localparam int B_TXSRC = 3;
  localparam int B_RXSRC = 2;
  localparam int B_HIRATE = 1;
  localparam int B_MODE0_RATE_SOURCE = 0;
  // Reset values
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [4:0] RST_BGCTL = 5'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Ticks per bit: doubled rate, normal rate
  localparam logic [4:0] LAST_FAST = 5'h0f;
  localparam logic [4:0] LAST_SLOW = 5'h1f;
  localparam logic [4:0] MID_FAST = 5'h07;
  localparam logic [4:0] MID_SLOW = 5'h0f;
  // Low speed generator prescale, clocks per count
  localparam logic [2:0] LOW_DIV_LAST = 3'h5;
  // Frame lengths on the wire, start and stop included
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] FRAME9 = 4'hb;
  // Receive sample index of ninth or stop bit
  localparam logic [3:0] IDX_B8 = 4'h8;
  localparam logic [3:0] IDX_B9 = 4'h9;
  // Register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spa_sfr_req_t;
  // Plain control inputs from other registers of the core
  typedef struct packed {
    logic framing_error_select;
    logic baud_double;
    logic serial_irq_enable;
    logic global_irq_enable;
  } spa_ctl_t;
endpackage : spa_pkg

// >>> core/spa_serial_port.sv
// Purpose: serial port registers, framer, address filter, baud generator
// Assumes: one clock, core registers written in a single cycle
// Notes: timer 1 overflow comes from logic on the same clock
`timescale 1ns/10ps
module spa_serial_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input spa_pkg::spa_sfr_req_t sfr,
  input spa_pkg::spa_ctl_t ctl,
  input wire logic timer1_overflow,
  input wire logic rxd,
  output logic [7:0] sfr_rdata,
  output logic txd,
  output logic serial_irq
);
  import spa_pkg::*;

  typedef enum logic {TX_IDLE, TX_SHIFT} spa_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} spa_rx_t;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic mode_select_low, mode_select_high, multiproc_enable;
  logic rx_enable, tx_ninth_bit, rx_ninth_bit;
  logic tx_done_flag, rx_done_flag, framing_error_flag;
  logic [7:0] slave_own_address, slave_address_mask;
  logic [7:0] baud_reload_value, rx_buffer;
  logic [4:0] bgctl;
  // Decoded fields
  logic [1:0] mode;
  logic nine, fe_sel;
  logic wr_sctl, wr_serial_buffer;
  // Event strobes from the framers
  logic tx_fin_ev, rx_done_ev, fe_ev;
  logic [7:0] rx_data;
  logic rx_b8_val;

  // Mode field from bits 7 and 6
  assign mode = {mode_select_low, mode_select_high};
  assign nine = mode[1];
  assign fe_sel = ctl.framing_error_select;
  assign wr_sctl = sfr.wr && sfr.addr == ADDR_SCTL;
  assign wr_serial_buffer = sfr.wr && sfr.addr == ADDR_SERIAL_BUFFER;

  ////////////////////////////////////////////////////////////////////////
  // Serial control writes; bit 7 goes to the mode or the error flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_select_low <= 1'b0;
      mode_select_high <= 1'b0;
      multiproc_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
    end else if (wr_sctl) begin
      // Bit 7 is the mode bit only without error select
      if (!fe_sel) begin
        mode_select_low <= sfr.wdata[B_MODE_LO];
      end
      mode_select_high <= sfr.wdata[B_MODE_HI];
      multiproc_enable <= sfr.wdata[B_MP_EN];
      rx_enable <= sfr.wdata[B_RX_EN];
      tx_ninth_bit <= sfr.wdata[B_TX9];
    end
  end

  // Flags: a hardware set in the same cycle beats a software write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
    end else begin
      // Transmit flag set after last data bit
      if (tx_fin_ev) begin
        tx_done_flag <= 1'b1;
      end else if (wr_sctl) begin
        tx_done_flag <= sfr.wdata[B_TI];
      end
      // Receive flag set by accepted frame
      if (rx_done_ev) begin
        rx_done_flag <= 1'b1;
      end else if (wr_sctl) begin
        rx_done_flag <= sfr.wdata[B_RI];
      end
      // Error flag set by hardware, cleared by software
      if (fe_ev) begin
        framing_error_flag <= 1'b1;
      end else if (wr_sctl && fe_sel && !sfr.wdata[B_MODE_LO]) begin
        framing_error_flag <= 1'b0;
      end
      // Capture stop or ninth bit; mode 0 leaves it
      if (rx_done_ev && mode != 2'd0) begin
        rx_ninth_bit <= rx_b8_val;
      end else if (wr_sctl) begin
        rx_ninth_bit <= sfr.wdata[B_RX9];
      end
    end
  end

  // Address, mask, reload and generator control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_own_address <= RST_ADDR;
      slave_address_mask <= RST_ADDR;
      baud_reload_value <= RST_RELOAD;
      bgctl <= RST_BGCTL;
    end else if (sfr.wr) begin
      if (sfr.addr == ADDR_SADR) slave_own_address <= sfr.wdata;
      if (sfr.addr == ADDR_SMSK) slave_address_mask <= sfr.wdata;
      if (sfr.addr == ADDR_RELOAD) baud_reload_value <= sfr.wdata;
      // Reserved upper bits are not stored
      if (sfr.addr == ADDR_BGCTL) bgctl <= sfr.wdata[4:0];
    end
  end

  // Received byte lands in the buffer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buffer <= RST_BYTE;
    end else if (rx_done_ev) begin
      rx_buffer <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered read mux; unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= RST_BYTE;
    end else if (sfr.rd) begin
      unique case (sfr.addr)
        ADDR_SCTL: sfr_rdata <= {fe_sel ? framing_error_flag :
          mode_select_low, mode_select_high, multiproc_enable,
          rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag,
          rx_done_flag};
        ADDR_SERIAL_BUFFER: sfr_rdata <= rx_buffer;
        ADDR_SADR: sfr_rdata <= slave_own_address;
        ADDR_SMSK: sfr_rdata <= slave_address_mask;
        ADDR_RELOAD: sfr_rdata <= baud_reload_value;
        ADDR_BGCTL: sfr_rdata <= {3'h0, bgctl};
        default: sfr_rdata <= RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One request, gated by both enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= (tx_done_flag | rx_done_flag) &
        ctl.serial_irq_enable & ctl.global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal baud generator
  logic [7:0] brg_cnt;
  logic [2:0] brg_pre;
  logic brg_tick, brg_step;
  // High rate counts every clock, low rate every sixth
  assign brg_step = bgctl[B_HIRATE] || brg_pre == LOW_DIV_LAST;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_pre <= 3'h0;
    end else if (!bgctl[B_RUN] || brg_pre == LOW_DIV_LAST) begin
      brg_pre <= 3'h0;
    end else begin
      brg_pre <= brg_pre + 3'h1;
    end
  end

  // Count up from reload, tick on overflow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_cnt <= RST_RELOAD;
      brg_tick <= 1'b0;
    end else if (!bgctl[B_RUN]) begin
      brg_cnt <= baud_reload_value;
      brg_tick <= 1'b0;
    end else if (brg_step) begin
      brg_tick <= brg_cnt == 8'hff;
      brg_cnt <= brg_cnt == 8'hff ? baud_reload_value : brg_cnt + 8'h01;
    end else begin
      brg_tick <= 1'b0;
    end
  end

  // Tick sources per direction; mode 2 runs off the clock itself
  logic tx_tick, rx_tick;
  logic [4:0] sub_last, sub_mid;
  always_comb begin
    tx_tick = 1'b1;
    rx_tick = 1'b1;
    if (mode == 2'd0) begin
      // Mode 0 variable or fixed rate
      tx_tick = bgctl[B_MODE0_RATE_SOURCE] ? brg_tick : 1'b1;
      rx_tick = tx_tick;
    end else if (mode != 2'd2) begin
      // Generator or timer 1 per direction
      tx_tick = bgctl[B_TXSRC] ? brg_tick : timer1_overflow;
      rx_tick = bgctl[B_RXSRC] ? brg_tick : timer1_overflow;
    end
  end
  // Doubling halves the ticks per bit: 16 or 32
  assign sub_last = ctl.baud_double ? LAST_FAST : LAST_SLOW;
  assign sub_mid = ctl.baud_double ? MID_FAST : MID_SLOW;

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: start, data LSB first, optional ninth, stop
  spa_tx_t tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic [4:0] tx_sub;
  logic tx_bit_end;
  assign tx_bit_end = tx_tick && tx_sub == sub_last;
  // Flag rises as the stop bit begins, last data bit sent
  assign tx_fin_ev = tx_state == TX_SHIFT && tx_bit_end &&
    tx_left == 4'h2;

  // A write while busy restarts the frame; software waits for the flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_left <= 4'h0;
      tx_sub <= 5'h00;
    end else if (wr_serial_buffer) begin
      tx_state <= TX_SHIFT;
      tx_shift <= {1'b1, nine ? tx_ninth_bit : 1'b1, sfr.wdata, 1'b0};
      tx_left <= nine ? FRAME9 : FRAME8;
      tx_sub <= 5'h00;
    end else if (tx_state == TX_SHIFT && tx_tick) begin
      tx_sub <= tx_bit_end ? 5'h00 : tx_sub + 5'h01;
      if (tx_bit_end) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1) tx_state <= TX_IDLE;
      end
    end
  end

  // Line driven from a flop; idle high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd <= 1'b1;
    end else begin
      txd <= tx_state == TX_SHIFT ? tx_shift[0] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: two-flop synchroniser, then edge detect on stage two
  logic rx_meta, rx_in, rx_prev;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_in <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= rxd;
      rx_in <= rx_meta;
      rx_prev <= rx_in;
    end
  end

  spa_rx_t rx_state;
  logic [4:0] rx_sub;
  logic [3:0] rx_cnt;
  logic rx_b8, rx_sample, rx_last, stop_seen;
  logic addr_given, addr_bcast, accept;
  logic [7:0] bcast;
  assign rx_sample = rx_tick && rx_sub == sub_mid;
  // Finish at ninth bit, or at stop in 8-bit modes or when checked
  assign stop_seen = !(nine && rx_cnt == IDX_B8);
  assign rx_last = rx_state == RX_DATA && rx_sample &&
    ((rx_cnt == IDX_B8 && !(nine && fe_sel)) || rx_cnt == IDX_B9);
  assign rx_b8_val = rx_cnt == IDX_B8 ? rx_in : rx_b8;
  // Given address: equal where mask is one
  assign addr_given = ((rx_data ^ slave_own_address) &
    slave_address_mask) == 8'h00;
  // Broadcast: OR of address and mask
  assign bcast = slave_own_address | slave_address_mask;
  assign addr_bcast = ((rx_data ^ bcast) & bcast) == 8'h00;
  // Filter only with recognition on, never in mode 0
  assign accept = !(multiproc_enable && mode != 2'd0) ||
    (rx_b8_val && (addr_given || addr_bcast));
  // Receive flag only for an accepted frame
  assign rx_done_ev = rx_last && accept;
  // Invalid stop flags an error when selected
  assign fe_ev = rx_last && stop_seen && !rx_in && fe_sel;

  // Frames start only while the receiver is enabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_sub <= 5'h00;
      rx_cnt <= 4'h0;
      rx_data <= RST_BYTE;
      rx_b8 <= 1'b0;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          rx_sub <= 5'h00;
          rx_cnt <= 4'h0;
          if (rx_enable && rx_prev && !rx_in) rx_state <= RX_START;
        end
        RX_START, RX_DATA: begin
          if (rx_tick) begin
            rx_sub <= rx_sub == sub_last ? 5'h00 : rx_sub + 5'h01;
          end
          if (!rx_enable) begin
            rx_state <= RX_IDLE;
          end else if (rx_sample && rx_state == RX_START) begin
            // False start on a high sample
            rx_state <= rx_in ? RX_IDLE : RX_DATA;
          end else if (rx_sample) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt < IDX_B8) rx_data <= {rx_in, rx_data[7:1]};
            if (rx_cnt == IDX_B8) rx_b8 <= rx_in;
            if (rx_last) rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_irq_gating: assert property (((tx_done_flag | rx_done_flag) &&
    ctl.serial_irq_enable && ctl.global_irq_enable) |=> serial_irq)
    else $error("request not raised");
  a_irq_needs_en: assert property (!ctl.global_irq_enable |=>
    !serial_irq) else $error("request without global enable");
  a_ti_set_wins: assert property (tx_fin_ev |=> tx_done_flag)
    else $error("transmit flag lost");
  a_ri_set_wins: assert property (rx_done_ev |=> rx_done_flag)
    else $error("receive flag lost");
  a_ri_held: assert property (rx_done_flag && !wr_sctl |=>
    rx_done_flag) else $error("receive flag cleared by hw");
  a_filter_drop: assert property (rx_last && multiproc_enable &&
    mode != 2'd0 && !rx_b8_val |=> !rx_done_flag || $past(rx_done_flag))
    else $error("unaddressed frame accepted");
  a_rx_gate: assert property (rx_state == RX_IDLE && !rx_enable |=>
    rx_state == RX_IDLE) else $error("receiver ran disabled");
  a_brg_stopped: assert property (!bgctl[B_RUN] |=> !brg_tick)
    else $error("generator ticked while stopped");
  a_tx_frame_line: assert property (wr_serial_buffer |=> ##1 !txd)
    else $error("no start bit after write");
  a_fe_sticky: assert property (framing_error_flag && !wr_sctl |=>
    framing_error_flag) else $error("error flag dropped");

  c_tx_done: cover property (tx_fin_ev);
  c_rx_done: cover property (rx_done_ev && nine);
  c_bcast: cover property (rx_done_ev && multiproc_enable &&
    addr_bcast && !addr_given);
  c_fe: cover property (fe_ev);
endmodule : spa_serial_port

// >>> testbench/spa_line_peer.sv
// Purpose: far end of the serial line, sends and captures frames
// Assumes: bit time given in sys_clk cycles, line idles high
// Notes: stop level is an argument so that bad stop bits can be sent
`timescale 1ns/10ps
module spa_line_peer (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd
);
  // Async line rests at mark level between frames
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // Start bit, nbits LSB first, then the given stop level and idle
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop, input int bit_clk);
    @(posedge sys_clk);
    #1 rxd = 1'b0;
    repeat (bit_clk) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      #1 rxd = data[i];
      repeat (bit_clk) @(posedge sys_clk);
    end
    #1 rxd = stop;
    repeat (bit_clk) @(posedge sys_clk);
    #1 rxd = 1'b1;
    repeat (bit_clk) @(posedge sys_clk);
  endtask : send
  ////////////////////////////////////////////////////////////////////////////
  // Wait bounded for a start bit, then sample each bit at its centre
  task automatic receive(input int nbits, input int bit_clk,
                         output logic [8:0] data, output logic ok);
    int wait_n;
    data = 9'h000;
    ok = 1'b0;
    wait_n = 0;
    // Bounded so a silent transmitter cannot hang the run
    while (txd !== 1'b0 && wait_n < 4000) begin
      @(posedge sys_clk);
      wait_n++;
    end
    if (txd === 1'b0) begin
      repeat (bit_clk / 2) @(posedge sys_clk);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_clk) @(posedge sys_clk);
        data[i] = txd;
      end
      // Stop bit must be at mark level
      repeat (bit_clk) @(posedge sys_clk);
      ok = (txd === 1'b1);
    end
  endtask : receive
endmodule : spa_line_peer

// >>> testbench/tb_spa_serial_port.sv
// Purpose: register level regression of the serial port block
// Assumes: register access takes one cycle, read data one cycle later
// Notes: timer 1 overflow is a bench pulse every second clock
`timescale 1ns/10ps
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  failures++; $display("unexpected at %0t: got %h expected %h", \
  $time, (got), (exp)); end end
module tb_spa_serial_port;
  import spa_pkg::*;
  // Receive case: control write, frame, expected control and buffer
  typedef struct packed {
    logic [7:0] ctlw;
    logic [8:0] frame;
    logic [7:0] sctl;
    logic [7:0] bufv;
  } spa_rx_case_t;
  localparam spa_rx_case_t RX_CASES [6] = '{
    '{8'hb0, 9'h157, 8'hb5, 8'h57}, '{8'hb0, 9'h1aa, 8'hb0, 8'h57},
    '{8'hb0, 9'h1ff, 8'hb5, 8'hff}, '{8'hb0, 9'h057, 8'hb0, 8'hff},
    '{8'h90, 9'h033, 8'h91, 8'h33}, '{8'h80, 9'h133, 8'h80, 8'h33}};
  logic sys_clk;
  logic rst_n;
  spa_sfr_req_t sfr;
  spa_ctl_t ctl;
  logic timer1_overflow;
  logic t1_run;
  logic rxd;
  logic [7:0] sfr_rdata;
  logic txd;
  logic serial_irq;
  int failures;
  int checked;
  logic [8:0] got9;
  logic ok;
  spa_serial_port spa_serial_port_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .sfr(sfr), .ctl(ctl), .timer1_overflow(timer1_overflow), .rxd(rxd),
    .sfr_rdata(sfr_rdata), .txd(txd), .serial_irq(serial_irq));
  spa_line_peer spa_line_peer_i (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Toggling gives one overflow pulse every second clock
  always @(posedge sys_clk) timer1_overflow <= #1 t1_run & ~timer1_overflow;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_clk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    #1 sfr.wr = 1'b0;
  endtask : reg_wr
  // Read data lands on the edge that takes the read
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    #1 sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    #1 sfr.rd = 1'b0;
    `CHECK(sfr_rdata, e)
  endtask : expect_reg
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // Whole run is about 6k clocks; this cuts a hang short
  initial begin
    #3_000_000;
    failures++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sfr = '0;
    ctl = '0;
    t1_run = 1'b0;
    timer1_overflow = 1'b0;
    failures = 0;
    checked = 0;
    rst_n = 1'b0;
    wait_clk(4);
    rst_n = 1'b1;
    expect_reg(ADDR_RELOAD, 8'h00);
    expect_reg(ADDR_BGCTL, 8'h00);
    expect_reg(ADDR_SADR, 8'h00);
    expect_reg(ADDR_SMSK, 8'h00);
    // storage, reserved bits never written as ones
    reg_wr(ADDR_RELOAD, 8'h5a);
    reg_wr(ADDR_BGCTL, 8'h1f);
    reg_wr(ADDR_SADR, 8'h56);
    reg_wr(ADDR_SMSK, 8'hfc);
    reg_wr(8'h90, 8'hff);
    expect_reg(ADDR_RELOAD, 8'h5a);
    expect_reg(ADDR_BGCTL, 8'h1f);
    expect_reg(ADDR_SADR, 8'h56);
    expect_reg(ADDR_SMSK, 8'hfc);
    expect_reg(8'h90, 8'h00);
    reg_wr(ADDR_BGCTL, 8'h00);
    // ninth bit and both mode 2 rates
    for (int k = 0; k < 2; k++) begin
      ctl.baud_double = (k == 0);
      reg_wr(ADDR_SCTL, k == 0 ? 8'h88 : 8'h80);
      reg_wr(ADDR_SERIAL_BUFFER, k == 0 ? 8'ha5 : 8'h3c);
      spa_line_peer_i.receive(9, k == 0 ? 16 : 32, got9, ok);
      `CHECK(got9, k == 0 ? 9'h1a5 : 9'h03c)
      `CHECK(ok, 1'b1)
      expect_reg(ADDR_SCTL, k == 0 ? 8'h8a : 8'h82);
    end
    ctl.serial_irq_enable = 1'b1;
    wait_clk(3);
    `CHECK(serial_irq, 1'b0)
    ctl.global_irq_enable = 1'b1;
    wait_clk(3);
    `CHECK(serial_irq, 1'b1)
    wait_clk(20);
    `CHECK(serial_irq, 1'b1)
    reg_wr(ADDR_SCTL, 8'h80);
    wait_clk(3);
    `CHECK(serial_irq, 1'b0)
    ctl.baud_double = 1'b1;
    for (int i = 0; i < 6; i++) begin
      reg_wr(ADDR_SCTL, RX_CASES[i].ctlw);
      spa_line_peer_i.send(RX_CASES[i].frame, 9, 1'b1, 16);
      expect_reg(ADDR_SCTL, RX_CASES[i].sctl);
      `CHECK(serial_irq, RX_CASES[i].sctl[0])
      expect_reg(ADDR_SERIAL_BUFFER, RX_CASES[i].bufv);
    end
    // mode 1 on timer ticks, bad then good stop
    t1_run = 1'b1;
    reg_wr(ADDR_SCTL, 8'h50);
    ctl.framing_error_select = 1'b1;
    spa_line_peer_i.send(9'h03c, 8, 1'b0, 32);
    expect_reg(ADDR_SCTL, 8'hd1);
    reg_wr(ADDR_SCTL, 8'h50);
    expect_reg(ADDR_SCTL, 8'h50);
    ctl.framing_error_select = 1'b0;
    spa_line_peer_i.send(9'h0c3, 8, 1'b1, 32);
    expect_reg(ADDR_SCTL, 8'h55);
    expect_reg(ADDR_SERIAL_BUFFER, 8'hc3);
    // generator at high then low rate
    t1_run = 1'b0;
    reg_wr(ADDR_RELOAD, 8'hfe);
    for (int k = 0; k < 2; k++) begin
      reg_wr(ADDR_BGCTL, k == 0 ? 8'h1a : 8'h18);
      reg_wr(ADDR_SCTL, 8'h40);
      reg_wr(ADDR_SERIAL_BUFFER, 8'h96);
      spa_line_peer_i.receive(8, k == 0 ? 32 : 192, got9, ok);
      `CHECK(got9, 9'h096)
      expect_reg(ADDR_SCTL, 8'h42);
    end
    reg_wr(ADDR_BGCTL, 8'h0a);
    reg_wr(ADDR_SCTL, 8'h40);
    reg_wr(ADDR_SERIAL_BUFFER, 8'h69);
    wait_clk(1000);
    expect_reg(ADDR_SCTL, 8'h40);
    test_done();
  end
endmodule : tb_spa_serial_port
